// ### rtl/cpu_bus_pkg.sv
// Purpose: Shared constants and types for the processor bus core.
// Assumes: 40 MHz system clock; Wishbone classic register access.
// Notes:   Pin groups travel as packed structs declared here.

package cpu_bus_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int unsigned CLK_HZ     = 40_000_000;
	localparam int unsigned F_SLOW_HZ  = 1_000_000;
	localparam int unsigned F_MID_HZ   = 2_000_000;
	localparam int unsigned F_FAST_HZ  = 3_000_000;
	localparam logic [5:0]  PER_SLOW   = 6'(CLK_HZ / F_SLOW_HZ);
	localparam logic [5:0]  PER_MID    = 6'(CLK_HZ / F_MID_HZ);
	localparam logic [5:0]  PER_FAST   = 6'(CLK_HZ / F_FAST_HZ);
	localparam int unsigned POR_MS     = 10;
	localparam int unsigned POR_DEF    = CLK_HZ / 1000 * POR_MS;
	localparam int          POR_W      = 20;

	// Speed link codes
	localparam logic [1:0]  SPD_SLOW   = 2'h0;
	localparam logic [1:0]  SPD_MID    = 2'h1;
	localparam logic [1:0]  SPD_FAST   = 2'h2;

	// ****************************************
	// Vectors, stack, status flags, opcodes
	// ****************************************
	localparam logic [15:0] VEC_NMI_LO = 16'hfffa;
	localparam logic [15:0] VEC_NMI_HI = 16'hfffb;
	localparam logic [15:0] VEC_RST_LO = 16'hfffc;
	localparam logic [15:0] VEC_RST_HI = 16'hfffd;
	localparam logic [15:0] VEC_IRQ_LO = 16'hfffe;
	localparam logic [15:0] VEC_IRQ_HI = 16'hffff;
	localparam logic [8:0]  SP_RESET   = 9'h1ff;
	localparam logic [7:0]  P_RESET    = 8'h24;
	localparam int          P_I        = 2;
	localparam int          P_B        = 4;
	localparam logic [7:0]  OP_CLI     = 8'h58;
	localparam logic [7:0]  OP_SEI     = 8'h78;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0]  REG_CTRL   = 8'h00;
	localparam logic [7:0]  REG_STATE  = 8'h04;
	localparam logic [7:0]  REG_FLAGS  = 8'h08;
	localparam logic [7:0]  REG_ISTAT  = 8'h0c;
	localparam logic [7:0]  REG_IMASK  = 8'h10;
	localparam int          STATE_SP   = 16;
	localparam int          FLAGS_HALT = 8;
	localparam int          INT_W      = 4;
	localparam int          INT_RESET  = 0;
	localparam int          INT_IRQ    = 1;
	localparam int          INT_NMI    = 2;
	localparam int          INT_HALT   = 3;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {
		ST_HOLD, ST_RST_VL, ST_RST_VH, ST_FETCH, ST_PUSH_H,
		ST_PUSH_L, ST_PUSH_P, ST_VEC_L, ST_VEC_H
	} cyc_e;

	typedef struct packed {
		logic [7:0] data_in;
		logic       bus_request_n;
		logic       maskable_interrupt_request_n;
		logic       unmaskable_interrupt_n;
		logic       power_on_clear_n;
	} proc_in_s;

	typedef struct packed {
		logic [15:0] addr;
		logic        addr_oe;
		logic [7:0]  data;
		logic        data_oe;
		logic        rw;
		logic        rw_oe;
		logic        sync;
		logic        phi2;
		logic        bus_handover_n;
	} proc_pins_s;

	typedef struct packed {
		cyc_e             st;
		logic [5:0]       cnt;
		logic [1:0]       speed;
		logic [15:0]      program_counter;
		logic [8:0]       sp;
		logic [7:0]       p;
		logic [7:0]       vec_lo;
		logic             vec_nmi;
		logic             nmi_pend;
		logic [POR_W-1:0] por_cnt;
		logic [1:0]       rq_s;
		logic [1:0]       irq_s;
		logic [1:0]       pcl_s;
		logic [2:0]       nmi_s;
		logic [7:0]       din_a;
		logic [7:0]       din_b;
		proc_pins_s       pins;
		logic             wb_ack;
		logic [31:0]      wb_dat;
		logic [INT_W-1:0] int_stat;
		logic [INT_W-1:0] int_mask;
		logic             irq;
	} core_s;

endpackage : cpu_bus_pkg

// ### rtl/cpu_bus_core.sv
// Purpose: Processor-side bus sequencer of an 8-bit processor board.
// Assumes: One 40 MHz clock; phase-zero made by an internal divider.
// Notes:   Opcodes other than the two mask opcodes execute as one-byte no-ops.

`timescale 1ns/1ps
`default_nettype none

module cpu_bus_core #(
	parameter int unsigned POR_CYCLES = cpu_bus_pkg::POR_DEF
) (
	// Clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    sys_rst,
	// Processor pins
	input  wire cpu_bus_pkg::proc_in_s   pins_i,
	output var  cpu_bus_pkg::proc_pins_s pins_o,
	// Wishbone slave
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	input  wire logic                    wb_we_i,
	input  wire logic [7:0]              wb_adr_i,
	input  wire logic [3:0]              wb_sel_i,
	input  wire logic [31:0]             wb_dat_i,
	output logic      [31:0]             wb_dat_o,
	output logic                         wb_ack_o,
	// Interrupt
	output logic                         irq_o
);
	import cpu_bus_pkg::*;

	// ****************************************
	// Helper functions
	// ****************************************

	// Phase-zero period for the link setting; spare code runs slow
	function automatic logic [5:0] period(input logic [1:0] spd);
		unique case (spd)
			SPD_MID:  period = PER_MID;
			SPD_FAST: period = PER_FAST;
			default:  period = PER_SLOW;
		endcase
	endfunction : period

	// Address driven in a given machine cycle
	function automatic logic [15:0] cyc_addr(input core_s c);
		unique case (c.st)
			ST_RST_VL: cyc_addr = VEC_RST_LO;
			ST_RST_VH: cyc_addr = VEC_RST_HI;
			ST_PUSH_H,
			ST_PUSH_L,
			ST_PUSH_P: cyc_addr = {7'h0, c.sp};
			ST_VEC_L:  cyc_addr = c.vec_nmi ? VEC_NMI_LO : VEC_IRQ_LO;
			ST_VEC_H:  cyc_addr = c.vec_nmi ? VEC_NMI_HI : VEC_IRQ_HI;
			default:   cyc_addr = c.program_counter;
		endcase
	endfunction : cyc_addr

	// Register read multiplexer; unmapped words read zero
	function automatic logic [31:0] rd_word(input core_s c, input logic [7:0] a);
		rd_word = 32'h0;
		unique case (a)
			REG_CTRL:  rd_word[1:0] = c.speed;
			REG_STATE: rd_word = {7'h0, c.sp, c.program_counter};
			REG_FLAGS: rd_word = {23'h0, c.pins.bus_handover_n, c.p};
			REG_ISTAT: rd_word[INT_W-1:0] = c.int_stat;
			REG_IMASK: rd_word[INT_W-1:0] = c.int_mask;
			default:   rd_word = 32'h0;
		endcase
	endfunction : rd_word

	// ****************************************
	// State and reset value
	// ****************************************
	localparam proc_pins_s PINS_RST = '{rw: 1'b1, default: '0};
	localparam core_s CORE_RST = '{
		st: ST_HOLD, sp: SP_RESET, p: P_RESET, pins: PINS_RST,
		irq_s: 2'h3, rq_s: 2'h3, nmi_s: 3'h7, default: '0
	};
	localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYCLES - 1);

	core_s      s;
	core_s      nxt_s;
	logic [5:0] per;
	logic [5:0] half;
	logic       cyc_end;
	logic       rise0;
	logic       hold_req;
	logic       stall;
	logic       advance;
	logic       wb_hit;
	logic       wb_wr;

	// Cycle timing and advance conditions
	assign per      = period(s.speed);
	assign half     = per >> 1;
	assign cyc_end  = s.cnt >= per - 6'h1;
	assign rise0    = s.cnt == half - 6'h1;
	assign hold_req = (s.por_cnt != POR_LAST) || !s.pcl_s[1];
	assign stall    = s.pins.bus_handover_n && s.pins.rw;
	assign advance  = cyc_end && !hold_req && !stall;
	assign wb_hit   = wb_cyc_i && wb_stb_i;
	assign wb_wr    = wb_hit && wb_we_i && s.wb_ack && wb_sel_i[0];

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		nxt_s = s;

		// Two-flop pin synchronisers; nmi gets a third for the edge
		nxt_s.rq_s  = {s.rq_s[0], pins_i.bus_request_n};
		nxt_s.irq_s = {s.irq_s[0], pins_i.maskable_interrupt_request_n};
		nxt_s.pcl_s = {s.pcl_s[0], pins_i.power_on_clear_n};
		nxt_s.nmi_s = {s.nmi_s[1:0], pins_i.unmaskable_interrupt_n};
		nxt_s.din_a = pins_i.data_in;
		nxt_s.din_b = s.din_a;

		// Power-on hold counter saturates, then waits for clear high
		if (s.por_cnt != POR_LAST) begin
			nxt_s.por_cnt = s.por_cnt + POR_W'(1);
		end

		// Phase-zero divider; a slower link just lets cnt run out
		nxt_s.cnt = cyc_end ? 6'h0 : s.cnt + 6'h1;

		// Latch a falling unmaskable edge; set wins over clear
		if (s.nmi_s[2] && !s.nmi_s[1]) begin
			nxt_s.nmi_pend = 1'b1;
		end

		// Ready flop moves only on the phase-zero rising edge
		if (rise0) begin
			if (!s.rq_s[1] && s.pins.rw) begin
				nxt_s.pins.bus_handover_n = 1'b1;
			end else if (s.rq_s[1]) begin
				nxt_s.pins.bus_handover_n = 1'b0;
			end
		end

		// Machine-cycle sequencer
		if (hold_req) begin
			nxt_s.st  = ST_HOLD;
			nxt_s.sp  = SP_RESET;
			nxt_s.p   = P_RESET;
			nxt_s.cnt = 6'h0;
		end else if (cyc_end && !stall && s.st == ST_HOLD) begin
			nxt_s.st = ST_RST_VL;
		end else if (advance) begin
			unique case (s.st)
				ST_RST_VL: begin
					nxt_s.vec_lo = s.din_b;
					nxt_s.st     = ST_RST_VH;
				end
				ST_RST_VH: begin
					nxt_s.program_counter = {s.din_b, s.vec_lo};
					nxt_s.st              = ST_FETCH;
				end
				ST_FETCH: begin
					// Pending entry discards the opcode; PC is not stepped
					if (s.nmi_pend) begin
						nxt_s.vec_nmi  = 1'b1;
						nxt_s.nmi_pend = s.nmi_s[2] && !s.nmi_s[1];
						nxt_s.st       = ST_PUSH_H;
					end else if (!s.irq_s[1] && !s.p[P_I]) begin
						nxt_s.vec_nmi = 1'b0;
						nxt_s.st      = ST_PUSH_H;
					end else begin
						nxt_s.program_counter = s.program_counter + 16'h1;
						if (s.din_b == OP_CLI) begin
							nxt_s.p[P_I] = 1'b0;
						end else if (s.din_b == OP_SEI) begin
							nxt_s.p[P_I] = 1'b1;
						end
					end
				end
				ST_PUSH_H,
				ST_PUSH_L: begin
					// Only PC and status go on the stack, no data registers
					nxt_s.sp = {1'b1, s.sp[7:0] - 8'h1};
					nxt_s.st = (s.st == ST_PUSH_H) ? ST_PUSH_L : ST_PUSH_P;
				end
				ST_PUSH_P: begin
					nxt_s.sp     = {1'b1, s.sp[7:0] - 8'h1};
					nxt_s.p[P_I] = 1'b1;
					nxt_s.st     = ST_VEC_L;
				end
				ST_VEC_L: begin
					nxt_s.vec_lo = s.din_b;
					nxt_s.st     = ST_VEC_H;
				end
				ST_VEC_H: begin
					nxt_s.program_counter = {s.din_b, s.vec_lo};
					nxt_s.st              = ST_FETCH;
				end
				default: nxt_s.st = ST_HOLD;
			endcase
		end

		// Pins follow the next machine state
		nxt_s.pins.addr    = cyc_addr(nxt_s);
		nxt_s.pins.rw      = !(nxt_s.st inside {ST_PUSH_H, ST_PUSH_L, ST_PUSH_P});
		unique case (nxt_s.st)
			ST_PUSH_H: nxt_s.pins.data = nxt_s.program_counter[15:8];
			ST_PUSH_L: nxt_s.pins.data = nxt_s.program_counter[7:0];
			ST_PUSH_P: nxt_s.pins.data = nxt_s.p & ~(8'h1 << P_B);
			default:   nxt_s.pins.data = 8'h0;
		endcase
		nxt_s.pins.phi2    = nxt_s.cnt >= half;
		nxt_s.pins.data_oe = !nxt_s.pins.rw && nxt_s.pins.phi2;
		nxt_s.pins.sync    = nxt_s.st == ST_FETCH;
		nxt_s.pins.addr_oe = !nxt_s.pins.bus_handover_n;
		nxt_s.pins.rw_oe   = !nxt_s.pins.bus_handover_n;

		// Wishbone: ack one cycle after the strobe, write at the ack edge
		nxt_s.wb_ack = wb_hit && !s.wb_ack;
		nxt_s.wb_dat = rd_word(s, wb_adr_i);
		if (wb_wr && wb_adr_i == REG_CTRL) begin
			nxt_s.speed = wb_dat_i[1:0];
		end
		if (wb_wr && wb_adr_i == REG_IMASK) begin
			nxt_s.int_mask = wb_dat_i[INT_W-1:0];
		end

		// Sticky events: clear first so a same-cycle event survives
		if (wb_wr && wb_adr_i == REG_ISTAT) begin
			nxt_s.int_stat = s.int_stat & ~wb_dat_i[INT_W-1:0];
		end
		if (advance && s.st == ST_RST_VH) begin
			nxt_s.int_stat[INT_RESET] = 1'b1;
		end
		if (advance && s.st == ST_VEC_H) begin
			nxt_s.int_stat[s.vec_nmi ? INT_NMI : INT_IRQ] = 1'b1;
		end
		if (nxt_s.pins.bus_handover_n && !s.pins.bus_handover_n) begin
			nxt_s.int_stat[INT_HALT] = 1'b1;
		end
		nxt_s.irq = |(nxt_s.int_stat & nxt_s.int_mask);
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s <= CORE_RST;
		end else begin
			s <= nxt_s;
		end
	end

	// Outputs straight from the state flops
	assign pins_o   = s.pins;
	assign wb_dat_o = s.wb_dat;
	assign wb_ack_o = s.wb_ack;
	assign irq_o    = s.irq;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	sequence s_fetch_end;
		s.st == ST_FETCH && advance && !s.nmi_pend;
	endsequence

	sequence s_irq_wanted;
		!s.irq_s[1] && !s.p[P_I];
	endsequence

	// Unmasked request enters the push sequence next
	AST_IRQ_ENTRY: assert property (s_fetch_end ##0 s_irq_wanted |=> s.st == ST_PUSH_H)
		else $error("unmasked request not taken");

	// Masked request never starts an entry
	AST_IRQ_MASKED: assert property (s_fetch_end ##0 (s.p[P_I] || s.irq_s[1])
		|=> s.st == ST_FETCH)
		else $error("masked request was taken");

	// Unmaskable entry reads the low vector byte at FFFA
	AST_NMI_VEC: assert property (s.st == ST_VEC_L && s.vec_nmi
		|-> s.pins.addr == VEC_NMI_LO)
		else $error("wrong unmaskable vector");

	// Plain step advances the program counter by one
	AST_PC_STEP: assert property (s_fetch_end ##0 (s.p[P_I] || s.irq_s[1])
		|=> s.program_counter == $past(s.program_counter) + 16'h1)
		else $error("program counter did not step");

	// Driving data only happens on write cycles
	AST_DATA_DIR: assert property (s.pins.data_oe |-> !s.pins.rw)
		else $error("data driven on a read");

	// Buffers released within a cycle of handover going high
	AST_BUF_OFF: assert property ($rose(s.pins.bus_handover_n)
		|-> !s.pins.addr_oe && !s.pins.rw_oe)
		else $error("buffers still driving during handover");

	// A halted read keeps its address
	AST_HALT_ADDR: assert property (s.pins.bus_handover_n && s.pins.rw && !hold_req
		|=> $stable(s.pins.addr))
		else $error("address moved while halted");

	// Halt only begins after a read was on the bus
	AST_HALT_WRITE: assert property ($rose(s.pins.bus_handover_n) |-> $past(s.pins.rw))
		else $error("halt entered during a write");

	// Reset sequence starts with FFFC and stack at 01FF
	AST_RESET_VEC: assert property (s.st == ST_RST_VL
		|-> s.pins.addr == VEC_RST_LO && s.sp == SP_RESET)
		else $error("bad reset fetch");

	// Low power-on clear forces the hold state
	AST_POR_HOLD: assert property (!s.pcl_s[1] |=> s.st == ST_HOLD ##1 s.st == ST_HOLD)
		else $error("ran while reset held");

	// Fetch marker only during opcode fetch
	AST_SYNC: assert property (s.pins.sync |-> s.st == ST_FETCH)
		else $error("marker outside fetch");

	// Phase two rises on the divider midpoint; a speed write moves the
	// midpoint, so the one cycle right after such a write is left out
	AST_PHI2: assert property (rise0 && !cyc_end && !hold_req && $stable(s.speed)
		|=> $rose(s.pins.phi2))
		else $error("phase two out of step");

	// Entry sets the interrupt mask flag before the vector read
	AST_FLAG_I: assert property (s.st == ST_PUSH_P && advance
		|=> s.st == ST_VEC_L && s.p[P_I])
		else $error("mask flag not set on entry");

endmodule : cpu_bus_core

`default_nettype wire

// ### dv/cpu_bus_far_end.sv
// Purpose: Far-side model: memory with vectors, and a DMA master.
// Assumes: Data is read straight from the address; no wait states.
// Notes:   Vectors lead to 0200, 0300 and 0400.
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_far_end (
	// Clock
	input  wire logic                    clk_sys,
	// Processor side
	input  wire cpu_bus_pkg::proc_pins_s pins,
	output logic [7:0]                   data_in,
	// DMA master
	input  wire logic                    dma_go,
	output logic                         bus_request_n
);
	import cpu_bus_pkg::*;
	logic [7:0] rd;
	logic [7:0] last_ff = 8'h00;
	logic       req_ff  = 1'b0;
	// ********
	// Memory
	// ********
	// Vector bytes; a mask-clear opcode at every xx05
	always_comb begin
		case (pins.addr)
			VEC_RST_HI: rd = 8'h02;
			VEC_NMI_HI: rd = 8'h03;
			VEC_IRQ_HI: rd = 8'h04;
			VEC_RST_LO, VEC_NMI_LO, VEC_IRQ_LO: rd = 8'h00;
			default: rd = (pins.addr[7:0] == 8'h05) ? OP_CLI : 8'hea;
		endcase
	end
	// Released bus toggles, so a stale byte never passes
	assign data_in = pins.addr_oe ? rd : ~last_ff;
	// Request only changes on a clock edge, like the backplane logic
	always_ff @(posedge clk_sys) begin
		last_ff <= data_in;
		req_ff  <= dma_go;
	end
	assign bus_request_n = ~req_ff;
endmodule : cpu_bus_far_end
`default_nettype wire

// ### dv/test_cpu_bus_core.sv
// Purpose: Self-checking bench for the processor bus core.
// Assumes: Power-on count shortened to 50 clocks.
// Notes:   Queues hold expected reads, fetch targets and pushes.
`timescale 1ns/1ps
`default_nettype none
module test_cpu_bus_core;
	import cpu_bus_pkg::*;
	localparam int LIMIT = 30000;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        ack;
	logic        irq;
	logic        irq_n = 1'b1;
	logic        nmi_n = 1'b1;
	logic        pocn = 1'b0;
	logic        dma_go = 1'b0;
	logic [7:0]  din;
	logic        brq_n;
	proc_pins_s  po;
	proc_in_s    pi;
	logic [63:0] exp_rd[$];
	logic [15:0] exp_pc[$];
	logic [24:0] exp_wr[$];
	logic [63:0] e;
	logic [24:0] w;
	logic [1:0]  s;
	logic        vec_seen = 1'b0;
	logic        sync_q = 1'b0;
	logic        doe_q = 1'b0;
	real         t0;
	int          n_fail = 0;
	int          n_compared = 0;
	int          tick = 0;
	int          n_early = 0;
	int          n_bad = 0;
	assign pi = '{data_in: din, bus_request_n: brq_n,
		maskable_interrupt_request_n: irq_n,
		unmaskable_interrupt_n: nmi_n, power_on_clear_n: pocn};
	cpu_bus_core #(.POR_CYCLES(50)) i_dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .pins_i(pi), .pins_o(po),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .irq_o(irq));
	cpu_bus_far_end i_far (.clk_sys(clk_sys), .pins(po), .data_in(din),
		.dma_go(dma_go), .bus_request_n(brq_n));
	// Clock, 25 ns
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	// ********
	// Tasks
	// ********
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Classic cycle; waits for ack however long it takes
	task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		wdat <= d;
		sel <= 4'h1;
		@(posedge clk_sys);
		while (ack !== 1'b1) @(posedge clk_sys);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		exp_rd.push_back({m, x});
		wb(1'b0, a, 32'h0);
	endtask : rd
	task automatic settle();
		repeat (3000) if (exp_pc.size() + exp_wr.size() > 0) @(posedge clk_sys);
		// A wait that runs out leaves notes behind and counts as a mismatch
		chk(32'(exp_pc.size() + exp_wr.size()), 32'h0);
	endtask : settle
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results
	// ********
	// Monitor
	// ********
	// Cycle ceiling; a hang counts as a mismatch and still reaches the verdict
	always @(posedge clk_sys) begin
		tick <= tick + 1;
		if (tick == LIMIT) begin
			n_fail++;
			results();
		end
	end
	// Takes the oldest note whenever a result shows up
	always @(posedge clk_sys) begin
		if (ack === 1'b1 && !we && exp_rd.size() > 0) begin
			e = exp_rd.pop_front();
			chk(rdat & e[63:32], e[31:0]);
		end
		if (po.addr === VEC_RST_HI || po.addr === VEC_NMI_HI || po.addr === VEC_IRQ_HI)
			vec_seen <= 1'b1;
		if (po.sync === 1'b1 && !sync_q && vec_seen && exp_pc.size() > 0) begin
			chk(32'(po.addr), 32'(exp_pc.pop_front()));
			chk(32'(po.rw), 32'h1);
			vec_seen <= 1'b0;
		end
		// Note layout: pushed byte, status flag, stack address
		if (po.data_oe === 1'b1 && !doe_q && exp_wr.size() > 0) begin
			w = exp_wr.pop_front();
			chk(32'(po.addr), 32'(w[15:0]));
			chk(32'(po.rw), 32'h0);
			chk(32'(po.data), 32'(w[24:17]));
			if (w[16]) chk(32'(po.data[P_B]), 32'h0);
		end
		if (!pocn && po.addr === VEC_RST_LO) n_early++;
		if (po.rw === 1'b0 && po.bus_handover_n === 1'b1) n_bad++;
		sync_q <= po.sync;
		doe_q <= po.data_oe;
	end
	// ********
	// Sequence
	// ********
	initial begin
		void'($urandom(19));
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		exp_pc.push_back(16'h0200);
		rd(REG_CTRL, 32'h3, 32'h0);
		rd(REG_IMASK, 32'hf, 32'h0);
		rd(REG_FLAGS, 32'h1ff, 32'h024);
		rd(REG_STATE, 32'h01ff0000, 32'h01ff0000);
		rd(8'h1c, 32'hffffffff, 32'h0);
		repeat (100) @(posedge clk_sys);
		chk(32'(n_early), 32'h0);
		pocn <= 1'b1;
		settle();
		$display("test reset done");
		// Unmaskable entry: three pushes, status with bit 4 clear
		// PC 0200 is pushed unstepped, then status 24h
		exp_wr = '{{8'h02, 1'b0, 16'h01ff}, {8'h00, 1'b0, 16'h01fe}, {8'h24, 1'b1, 16'h01fd}};
		exp_pc.push_back(16'h0300);
		nmi_n <= 1'b0;
		settle();
		nmi_n <= 1'b1;
		// Maskable entry with a DMA request landing mid-push; the mask-clear
		// opcode at 0305 unmasks it, so PC 0306 and status 20h are pushed
		exp_wr = '{{8'h03, 1'b0, 16'h01fc}, {8'h06, 1'b0, 16'h01fb}, {8'h20, 1'b1, 16'h01fa}};
		exp_pc.push_back(16'h0400);
		irq_n <= 1'b0;
		repeat (3000) if (po.data_oe !== 1'b1) @(posedge clk_sys);
		dma_go <= 1'b1;
		repeat (400) if (po.bus_handover_n !== 1'b1) @(posedge clk_sys);
		chk(32'(po.addr_oe), 32'h0);
		chk(32'(po.rw_oe), 32'h0);
		chk(32'(po.addr), 32'(VEC_IRQ_LO));
		rd(REG_FLAGS, 32'h100, 32'h100);
		// Halt leaves the stack where the three pushes put it
		rd(REG_STATE, 32'h01ff0000, 32'h01f90000);
		repeat (60) @(posedge clk_sys);
		chk(32'(po.addr), 32'(VEC_IRQ_LO));
		dma_go <= 1'b0;
		repeat (200) if (po.bus_handover_n !== 1'b0) @(posedge clk_sys);
		chk(32'(po.addr_oe), 32'h1);
		settle();
		irq_n <= 1'b1;
		chk(32'(n_bad), 32'h0);
		$display("test interrupt entry done");
		// Status sticky, masked, then raised and cleared
		rd(REG_ISTAT, 32'hf, 32'hf);
		chk(32'(irq), 32'h0);
		wb(1'b1, REG_IMASK, 32'h8);
		repeat (2) @(posedge clk_sys);
		chk(32'(irq), 32'h1);
		wb(1'b1, REG_ISTAT, 32'hf);
		repeat (2) @(posedge clk_sys);
		chk(32'(irq), 32'h0);
		rd(REG_ISTAT, 32'hf, 32'h0);
		$display("test status done");
		// Every speed code, then one random; 3 runs as the slow rate
		for (int i = 0; i < 4; i++) begin
			s = (i < 3) ? 2'(i) : 2'($urandom % 4);
			wb(1'b1, REG_CTRL, ($urandom & 32'hfffffffc) | 32'(s));
			rd(REG_CTRL, 32'h3, 32'(s));
			repeat (3) @(posedge po.phi2);
			t0 = $realtime;
			@(posedge po.phi2);
			chk(32'(int'(($realtime - t0) / 25.0)), 32'((s == SPD_MID) ? PER_MID :
				(s == SPD_FAST) ? PER_FAST : PER_SLOW));
		end
		$display("test speed done");
		results();
	end
endmodule : test_cpu_bus_core
`default_nettype wire
